// >>> verilog/timer_ctl_pkg.sv
// Package for the timer mode and control block: offsets, field positions,
// masks, encodings and the width-configuration type.
// Assumes a 32-bit register port with byte addresses.
package timer_ctl_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] OFS_CONFIG  = 8'h00;
	localparam logic [7:0] OFS_A_MODE  = 8'h04;
	localparam logic [7:0] OFS_B_MODE  = 8'h08;
	localparam logic [7:0] OFS_CONTROL = 8'h0c;
	localparam logic [7:0] OFS_STATUS  = 8'h10;

	// Writable bits and reset values
	localparam logic [31:0] CONFIG_MASK  = 32'h0000_0007;
	localparam logic [31:0] MODE_MASK    = 32'h0000_000f;
	localparam logic [31:0] CONTROL_MASK = 32'h0000_0f7f;
	localparam logic [31:0] RESET_WORD   = 32'h0000_0000;

	// Global width configuration field
	localparam int         CFG_LSB           = 0;
	localparam int         CFG_SPLIT_BIT     = 2;
	localparam logic [1:0] CFG_WIDE_TIMER    = 2'h0;
	localparam logic [1:0] CFG_WIDE_CALENDAR = 2'h1;

	// Per-half mode register fields
	localparam int MODE_SEL_LSB   = 0;
	localparam int CAPT_KIND_BIT  = 2;
	localparam int ALT_SELECT_BIT = 3;

	// Control register fields
	localparam int CTL_A_EN       = 0;
	localparam int CTL_A_FREEZE   = 1;
	localparam int CTL_A_EDGE_LSB = 2;
	localparam int CTL_CAL_EN     = 4;
	localparam int CTL_A_TRIG_EN  = 5;
	localparam int CTL_A_PWM_INV  = 6;
	localparam int CTL_B_EN       = 8;
	localparam int CTL_B_FREEZE   = 9;
	localparam int CTL_B_EDGE_LSB = 10;

	// Status register fields
	localparam int STS_A_RUN   = 0;
	localparam int STS_A_HOLD  = 1;
	localparam int STS_B_RUN   = 2;
	localparam int STS_B_HOLD  = 3;
	localparam int STS_CAL_RUN = 4;

	// Mode and edge encodings
	localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
	localparam logic [1:0] MODE_PERIODIC = 2'h2;
	localparam logic [1:0] MODE_CAPTURE  = 2'h3;
	localparam logic [1:0] EDGE_RISE     = 2'h0;
	localparam logic [1:0] EDGE_FALL     = 2'h1;
	localparam logic [1:0] EDGE_BOTH     = 2'h3;

	typedef enum logic [1:0] {
		cfg_wide_timer,
		cfg_wide_calendar,
		cfg_split,
		cfg_reserved
	} width_cfg_t;

endpackage : timer_ctl_pkg

// >>> verilog/half_cfg_if.sv
// Interface between the control register file and one half's decoder.
// Assumes one clock domain; the decode side is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface half_cfg_if;
	timer_ctl_pkg::width_cfg_t width_cfg;
	logic       is_b;
	logic [1:0] mode_sel;
	logic       capture_kind;
	logic       alt_select;
	logic [1:0] edge_sel;
	logic       freeze;
	logic       enable;
	logic       debug_halt;
	logic       one_shot;
	logic       periodic;
	logic       capture;
	logic       edge_time;
	logic       pwm;
	logic       rise_evt;
	logic       fall_evt;
	logic       hold;
	logic       run;

	modport cfg (output width_cfg, is_b, mode_sel, capture_kind, alt_select, edge_sel,
	             freeze, enable, debug_halt,
	             input one_shot, periodic, capture, edge_time, pwm, rise_evt, fall_evt, hold, run);
	modport dec (input width_cfg, is_b, mode_sel, capture_kind, alt_select, edge_sel,
	             freeze, enable, debug_halt,
	             output one_shot, periodic, capture, edge_time, pwm, rise_evt, fall_evt, hold, run);
endinterface : half_cfg_if
`default_nettype wire

// >>> verilog/half_mode_decode.sv
// Combinational mode, edge and hold decode for one timer half.
// Assumes its inputs come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module half_mode_decode (
	// Configuration in, decoded mode out
	half_cfg_if.dec h
);
	logic mode_ok;
	logic active;

	// Half B only lives in the split configuration; the wide timer config follows half A
	assign mode_ok = (h.width_cfg == timer_ctl_pkg::cfg_split) ||
	                 (!h.is_b && h.width_cfg == timer_ctl_pkg::cfg_wide_timer);
	assign active  = h.is_b ? (h.width_cfg == timer_ctl_pkg::cfg_split)
	                        : (h.width_cfg != timer_ctl_pkg::cfg_reserved);

	// Reserved mode code 0 selects nothing
	assign h.one_shot  = mode_ok && h.mode_sel == timer_ctl_pkg::MODE_ONE_SHOT;
	assign h.periodic  = mode_ok && h.mode_sel == timer_ctl_pkg::MODE_PERIODIC;
	assign h.capture   = mode_ok && h.mode_sel == timer_ctl_pkg::MODE_CAPTURE;
	assign h.edge_time = h.capture && h.capture_kind;
	assign h.pwm       = h.periodic && h.alt_select && !h.capture_kind;

	// Reserved edge code 2 counts no edge at all
	assign h.rise_evt = (h.edge_sel == timer_ctl_pkg::EDGE_RISE) ||
	                    (h.edge_sel == timer_ctl_pkg::EDGE_BOTH);
	assign h.fall_evt = (h.edge_sel == timer_ctl_pkg::EDGE_FALL) ||
	                    (h.edge_sel == timer_ctl_pkg::EDGE_BOTH);

	// Freeze bit only matters under debug halt
	assign h.hold = h.freeze && h.debug_halt && active;
	assign h.run  = h.enable && active && !h.hold;
endmodule : half_mode_decode
`default_nettype wire

// >>> verilog/timer_mode_ctl.sv
// Timer mode and control register block: global width configuration,
// per-half mode registers, control register and a status word.
// Assumes the processor drives the register port and debug halt on core_clk.
// Function
// - Half B mode code 1 one-shot, 2 periodic, 3 capture, 0 reserved.
// - Each mode field is read in light of the global width config.
// - In split 16-bit config, half B mode chooses B's operation independently.
// - In 32-bit config, half B mode is ignored; half A mode rules. In wide calendar config 1 the code ignores half A mode as well.
// - Control bits 11:10 select B edge: rise, fall, both; 2 reserved.
// - Bit 9 set freezes half B under debug halt, else it counts.
// - Bit 1 set freezes half A under debug halt, else it counts.
// - Without debug halt both freeze bits are ignored.
// - Bit 8 enables half B counting or capture; clear disables it.
// - Bit 0 enables half A counting or capture; clear disables it.
// - Bit 6 inverts half A's PWM output.
// - Bit 5 gates half A's trigger toward the converter.
// - Bit 4 enables calendar counting; clear stops it.
// - Control bits 3:2 select A edge: rise, fall, both; 2 reserved.
// - Config 0 wide timer, 1 wide calendar, 4 to 7 two halves.
// - Half B capture kind clear counts edges, set times edges.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module timer_mode_ctl #(
	parameter int ADDR_W = timer_ctl_pkg::ADDR_W
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// Register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	// Debug halt and raw signals from the counter core
	input  wire logic              debug_halt,
	input  wire logic              a_pwm_raw,
	input  wire logic              a_trigger_raw,
	// Half A decoded controls
	output logic                   a_run,
	output logic                   a_hold,
	output logic                   a_one_shot,
	output logic                   a_periodic,
	output logic                   a_capture,
	output logic                   a_edge_time,
	output logic                   a_pwm_mode,
	output logic                   a_rise_evt,
	output logic                   a_fall_evt,
	// Half B decoded controls
	output logic                   b_run,
	output logic                   b_hold,
	output logic                   b_one_shot,
	output logic                   b_periodic,
	output logic                   b_capture,
	output logic                   b_edge_time,
	output logic                   b_pwm_mode,
	output logic                   b_rise_evt,
	output logic                   b_fall_evt,
	// Shaped outputs
	output logic                   pwm_out,
	output logic                   converter_trigger,
	output logic                   calendar_run
);
	logic [31:0] cfg_ff;
	logic [31:0] a_mode_ff;
	logic [31:0] b_mode_ff;
	logic [31:0] ctl_ff;
	logic [31:0] rdata_ff;
	logic [8:0]  a_dec_ff;
	logic [8:0]  b_dec_ff;
	logic        pwm_out_ff;
	logic        trig_ff;
	logic        cal_run_ff;

	logic [31:0] nxt_cfg;
	logic [31:0] nxt_a_mode;
	logic [31:0] nxt_b_mode;
	logic [31:0] nxt_ctl;
	logic [31:0] nxt_rdata;
	logic [8:0]  nxt_a_dec;
	logic [8:0]  nxt_b_dec;

	logic        sel_cfg;
	logic        sel_a_mode;
	logic        sel_b_mode;
	logic        sel_ctl;
	logic        sel_sts;
	logic [31:0] status_word;
	logic [31:0] rd_word;

	timer_ctl_pkg::width_cfg_t width_cfg;
	logic [1:0] a_mode_sel;
	logic [1:0] b_mode_sel;
	logic [1:0] a_edge_sel;
	logic [1:0] b_edge_sel;
	logic       a_enable;
	logic       b_enable;
	logic       a_freeze;
	logic       b_freeze;
	logic       cal_en;
	logic       trig_en;
	logic       pwm_inv;

	// Address decode
	assign sel_cfg    = reg_addr == ADDR_W'(timer_ctl_pkg::OFS_CONFIG);
	assign sel_a_mode = reg_addr == ADDR_W'(timer_ctl_pkg::OFS_A_MODE);
	assign sel_b_mode = reg_addr == ADDR_W'(timer_ctl_pkg::OFS_B_MODE);
	assign sel_ctl    = reg_addr == ADDR_W'(timer_ctl_pkg::OFS_CONTROL);
	assign sel_sts    = reg_addr == ADDR_W'(timer_ctl_pkg::OFS_STATUS);

	// Writes keep only implemented bits so reserved bits always read zero
	assign nxt_cfg    = (reg_wr && sel_cfg) ? (reg_wdata & timer_ctl_pkg::CONFIG_MASK) : cfg_ff;
	assign nxt_a_mode = (reg_wr && sel_a_mode) ? (reg_wdata & timer_ctl_pkg::MODE_MASK) : a_mode_ff;
	assign nxt_b_mode = (reg_wr && sel_b_mode) ? (reg_wdata & timer_ctl_pkg::MODE_MASK) : b_mode_ff;
	assign nxt_ctl    = (reg_wr && sel_ctl) ? (reg_wdata & timer_ctl_pkg::CONTROL_MASK) : ctl_ff;

	// Read mux; unmapped addresses answer zero
	assign status_word = {27'h0000000, cal_run_ff, b_dec_ff[1], b_dec_ff[0], a_dec_ff[1], a_dec_ff[0]};
	assign rd_word = ({32{sel_cfg}} & cfg_ff) | ({32{sel_a_mode}} & a_mode_ff) |
	                 ({32{sel_b_mode}} & b_mode_ff) | ({32{sel_ctl}} & ctl_ff) |
	                 ({32{sel_sts}} & status_word);
	assign nxt_rdata = reg_rd ? rd_word : 32'h0000_0000;

	// Global width decode; any value with bit 2 set splits the halves
	assign width_cfg = cfg_ff[timer_ctl_pkg::CFG_SPLIT_BIT] ? timer_ctl_pkg::cfg_split :
	                   (cfg_ff[1:0] == timer_ctl_pkg::CFG_WIDE_TIMER) ? timer_ctl_pkg::cfg_wide_timer :
	                   (cfg_ff[1:0] == timer_ctl_pkg::CFG_WIDE_CALENDAR) ? timer_ctl_pkg::cfg_wide_calendar :
	                   timer_ctl_pkg::cfg_reserved;

	// Control field extraction
	assign a_mode_sel = a_mode_ff[timer_ctl_pkg::MODE_SEL_LSB +: 2];
	assign b_mode_sel = b_mode_ff[timer_ctl_pkg::MODE_SEL_LSB +: 2];
	assign a_edge_sel = ctl_ff[timer_ctl_pkg::CTL_A_EDGE_LSB +: 2];
	assign b_edge_sel = ctl_ff[timer_ctl_pkg::CTL_B_EDGE_LSB +: 2];
	assign a_enable   = ctl_ff[timer_ctl_pkg::CTL_A_EN];
	assign b_enable   = ctl_ff[timer_ctl_pkg::CTL_B_EN];
	assign a_freeze   = ctl_ff[timer_ctl_pkg::CTL_A_FREEZE];
	assign b_freeze   = ctl_ff[timer_ctl_pkg::CTL_B_FREEZE];
	assign cal_en     = ctl_ff[timer_ctl_pkg::CTL_CAL_EN];
	assign trig_en    = ctl_ff[timer_ctl_pkg::CTL_A_TRIG_EN];
	assign pwm_inv    = ctl_ff[timer_ctl_pkg::CTL_A_PWM_INV];

	// Per-half decoders
	half_cfg_if a_if ();
	half_cfg_if b_if ();

	assign a_if.width_cfg    = width_cfg;
	assign a_if.is_b         = 1'b0;
	assign a_if.mode_sel     = a_mode_sel;
	assign a_if.capture_kind = a_mode_ff[timer_ctl_pkg::CAPT_KIND_BIT];
	assign a_if.alt_select   = a_mode_ff[timer_ctl_pkg::ALT_SELECT_BIT];
	assign a_if.edge_sel     = a_edge_sel;
	assign a_if.freeze       = a_freeze;
	assign a_if.enable       = a_enable;
	assign a_if.debug_halt   = debug_halt;

	assign b_if.width_cfg    = width_cfg;
	assign b_if.is_b         = 1'b1;
	assign b_if.mode_sel     = b_mode_sel;
	assign b_if.capture_kind = b_mode_ff[timer_ctl_pkg::CAPT_KIND_BIT];
	assign b_if.alt_select   = b_mode_ff[timer_ctl_pkg::ALT_SELECT_BIT];
	assign b_if.edge_sel     = b_edge_sel;
	assign b_if.freeze       = b_freeze;
	assign b_if.enable       = b_enable;
	assign b_if.debug_halt   = debug_halt;

	half_mode_decode u_a_dec (.h(a_if.dec));
	half_mode_decode u_b_dec (.h(b_if.dec));

	assign nxt_a_dec = {a_if.fall_evt, a_if.rise_evt, a_if.pwm, a_if.edge_time, a_if.capture,
	                    a_if.periodic, a_if.one_shot, a_if.hold, a_if.run};
	assign nxt_b_dec = {b_if.fall_evt, b_if.rise_evt, b_if.pwm, b_if.edge_time, b_if.capture,
	                    b_if.periodic, b_if.one_shot, b_if.hold, b_if.run};

	// Register file
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cfg_ff    <= timer_ctl_pkg::RESET_WORD;
			a_mode_ff <= timer_ctl_pkg::RESET_WORD;
			b_mode_ff <= timer_ctl_pkg::RESET_WORD;
			ctl_ff    <= timer_ctl_pkg::RESET_WORD;
			rdata_ff  <= 32'h0000_0000;
		end else begin
			cfg_ff    <= nxt_cfg;
			a_mode_ff <= nxt_a_mode;
			b_mode_ff <= nxt_b_mode;
			ctl_ff    <= nxt_ctl;
			rdata_ff  <= nxt_rdata;
		end
	end

	// Output stage; one cycle of latency keeps every output on a flop
	always_ff @(posedge core_clk) begin
		if (rst) begin
			a_dec_ff   <= 9'h000;
			b_dec_ff   <= 9'h000;
			pwm_out_ff <= 1'b0;
			trig_ff    <= 1'b0;
			cal_run_ff <= 1'b0;
		end else begin
			a_dec_ff   <= nxt_a_dec;
			b_dec_ff   <= nxt_b_dec;
			pwm_out_ff <= a_pwm_raw ^ pwm_inv;
			trig_ff    <= a_trigger_raw && trig_en;
			cal_run_ff <= cal_en && width_cfg == timer_ctl_pkg::cfg_wide_calendar;
		end
	end

	assign reg_rdata         = rdata_ff;
	assign a_run             = a_dec_ff[0];
	assign a_hold            = a_dec_ff[1];
	assign a_one_shot        = a_dec_ff[2];
	assign a_periodic        = a_dec_ff[3];
	assign a_capture         = a_dec_ff[4];
	assign a_edge_time       = a_dec_ff[5];
	assign a_pwm_mode        = a_dec_ff[6];
	assign a_rise_evt        = a_dec_ff[7];
	assign a_fall_evt        = a_dec_ff[8];
	assign b_run             = b_dec_ff[0];
	assign b_hold            = b_dec_ff[1];
	assign b_one_shot        = b_dec_ff[2];
	assign b_periodic        = b_dec_ff[3];
	assign b_capture         = b_dec_ff[4];
	assign b_edge_time       = b_dec_ff[5];
	assign b_pwm_mode        = b_dec_ff[6];
	assign b_rise_evt        = b_dec_ff[7];
	assign b_fall_evt        = b_dec_ff[8];
	assign pwm_out           = pwm_out_ff;
	assign converter_trigger = trig_ff;
	assign calendar_run      = cal_run_ff;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_a_enable_write;
		reg_wr && sel_ctl && reg_wdata[timer_ctl_pkg::CTL_A_EN] && !debug_halt &&
		width_cfg == timer_ctl_pkg::cfg_wide_timer;
	endsequence

	sequence s_quiet;
		!reg_wr && !debug_halt;
	endsequence

	a_b_one_shot_decode: assert property (
		(width_cfg == timer_ctl_pkg::cfg_split && b_mode_sel == timer_ctl_pkg::MODE_ONE_SHOT)
		|=> (b_one_shot && !b_periodic && !b_capture))
		else $error("half B one-shot decode wrong");

	a_wide_ignores_b: assert property (
		(width_cfg == timer_ctl_pkg::cfg_wide_timer) |=> (!b_one_shot && !b_periodic && !b_capture && !b_run))
		else $error("half B active in wide config");

	a_wide_uses_a: assert property (
		(width_cfg == timer_ctl_pkg::cfg_wide_timer && a_mode_sel == timer_ctl_pkg::MODE_PERIODIC)
		|=> a_periodic)
		else $error("wide config not following half A mode");

	a_b_edge_both: assert property (
		(b_edge_sel == timer_ctl_pkg::EDGE_BOTH) |=> (b_rise_evt && b_fall_evt))
		else $error("half B both-edge select wrong");

	a_a_edge_reserved: assert property (
		(a_edge_sel == 2'h2) |=> (!a_rise_evt && !a_fall_evt))
		else $error("half A reserved edge code counts edges");

	a_b_freeze_hold: assert property (
		(debug_halt && b_freeze && b_enable && width_cfg == timer_ctl_pkg::cfg_split) |=> (b_hold && !b_run))
		else $error("half B not held under debug halt");

	a_a_freeze_hold: assert property (
		(debug_halt && a_freeze && a_enable && width_cfg != timer_ctl_pkg::cfg_reserved) |=> (a_hold && !a_run))
		else $error("half A not held under debug halt");

	a_no_halt_runs: assert property (
		(!debug_halt && a_enable && width_cfg != timer_ctl_pkg::cfg_reserved) |=> (a_run && !a_hold))
		else $error("freeze bit acted without debug halt");

	a_enable_reaches_run: assert property (
		s_a_enable_write ##1 s_quiet |=> a_run)
		else $error("half A enable write did not start it");

	a_b_disable_stops: assert property (
		!b_enable |=> !b_run)
		else $error("half B runs while disabled");

	a_pwm_invert_out: assert property (
		pwm_inv |=> (pwm_out != $past(a_pwm_raw)))
		else $error("PWM output not inverted");

	a_trigger_gated: assert property (
		!trig_en |=> !converter_trigger)
		else $error("converter trigger leaked while gated");

	a_calendar_stop: assert property (
		!cal_en |=> !calendar_run)
		else $error("calendar counts while disabled");

	a_reset_clears_ctl: assert property (
		$past(rst) |-> (ctl_ff == 32'h0000_0000 && cfg_ff == 32'h0000_0000 && !a_run && !b_run))
		else $error("control fields not zero after reset");

	a_read_one_cycle: assert property (
		(reg_rd && sel_ctl) |=> (reg_rdata == $past(ctl_ff)) ##1 (reg_rdata == 32'h0000_0000 || $past(reg_rd)))
		else $error("control readback timing wrong");

endmodule : timer_mode_ctl
`default_nettype wire

// >>> tb/core_stub.sv
// Stand-in for the counter core: raw half A PWM level and converter trigger.
// Assumes one clock shared with the control block; levels change after edges.
`timescale 1ns/1ps
`default_nettype none
module core_stub (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// Raw half A levels
	output logic      pwm_raw,
	output logic      trigger_raw
);
	logic [2:0] phase_ff;

	always_ff @(posedge core_clk) begin
		if (rst)
			phase_ff <= 3'h0;
		else
			phase_ff <= phase_ff + 3'h1;
	end

	// Uneven pattern so a stuck or unregistered output shows up
	assign pwm_raw     = phase_ff[1];
	assign trigger_raw = (phase_ff == 3'h5);
endmodule : core_stub
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the timer mode and control block.
// Assumes the core stub drives the raw PWM and trigger levels.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        core_clk   = 1'b0;
	logic        rst        = 1'b1;
	logic [7:0]  reg_addr   = 8'h00;
	logic [31:0] reg_wdata  = 32'h0000_0000;
	logic        reg_wr     = 1'b0;
	logic        reg_rd     = 1'b0;
	logic        debug_halt = 1'b0;
	logic [31:0] reg_rdata;
	logic [31:0] d;
	logic        a_pwm_raw, a_trigger_raw, r_p, r_t, pwm_out, converter_trigger, calendar_run;
	logic        a_run, a_hold, a_one_shot, a_periodic, a_capture, a_edge_time, a_pwm_mode, a_rise_evt, a_fall_evt;
	logic        b_run, b_hold, b_one_shot, b_periodic, b_capture, b_edge_time, b_pwm_mode, b_rise_evt, b_fall_evt;
	int          err_count   = 0;
	int          check_count = 0;

	always #10 core_clk = ~core_clk;

	core_stub u_core_stub (.core_clk(core_clk), .rst(rst), .pwm_raw(a_pwm_raw), .trigger_raw(a_trigger_raw));

	timer_mode_ctl #(.ADDR_W(8)) u_timer_mode_ctl (
		.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .debug_halt(debug_halt), .a_pwm_raw(a_pwm_raw),
		.a_trigger_raw(a_trigger_raw), .a_run(a_run), .a_hold(a_hold), .a_one_shot(a_one_shot),
		.a_periodic(a_periodic), .a_capture(a_capture), .a_edge_time(a_edge_time), .a_pwm_mode(a_pwm_mode),
		.a_rise_evt(a_rise_evt), .a_fall_evt(a_fall_evt), .b_run(b_run), .b_hold(b_hold),
		.b_one_shot(b_one_shot), .b_periodic(b_periodic), .b_capture(b_capture), .b_edge_time(b_edge_time),
		.b_pwm_mode(b_pwm_mode), .b_rise_evt(b_rise_evt), .b_fall_evt(b_fall_evt), .pwm_out(pwm_out),
		.converter_trigger(converter_trigger), .calendar_run(calendar_run));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask : rd

	// Decoded outputs trail the register by one edge
	task automatic settle;
		repeat (2) @(posedge core_clk);
		#1;
	endtask : settle

	task automatic halt(input logic h);
		@(posedge core_clk);
		debug_halt <= h;
		settle;
	endtask : halt

	function automatic logic [2:0] mf(input int m);
		return {m == 1, m == 2, m == 3};
	endfunction : mf

	function automatic logic [1:0] ef(input int e);
		return {e == 0 || e == 3, e == 1 || e == 3};
	endfunction : ef

	task automatic final_report;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report

	initial begin
		repeat (5000) @(posedge core_clk);
		err_count++;
		final_report;
	end

	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		// Reset words, last offset unmapped
		for (int i = 0; i < 6; i++) begin
			rd(8'(i * 4), d);
			check(d, 32'h0000_0000);
		end
		@(posedge core_clk);
		#1;
		check(reg_rdata, 32'h0000_0000);
		check(32'({a_run, a_hold, a_one_shot, a_periodic, a_capture, b_run, b_hold, b_one_shot, b_periodic,
			b_capture, pwm_out, converter_trigger, calendar_run}), 32'h0000_0000);
		// Writable bits; status is read-only, unmapped reads zero
		for (int i = 0; i < 6; i++)
			wr(8'(i * 4), 32'hffff_ffff);
		for (int i = 0; i < 6; i++) begin
			rd(8'(i * 4), d);
			case (i)
				0: check(d, timer_ctl_pkg::CONFIG_MASK);
				1, 2: check(d, timer_ctl_pkg::MODE_MASK);
				3: check(d, timer_ctl_pkg::CONTROL_MASK);
				4: check(d, 32'h0000_0005);
				default: check(d, 32'h0000_0000);
			endcase
		end
		for (int i = 0; i < 4; i++)
			wr(8'(i * 4), 32'h0000_0000);
		// Split configs: each half decodes its own mode
		wr(timer_ctl_pkg::OFS_CONTROL, 32'h0000_0101);
		for (int c = 4; c < 8; c++) begin
			for (int m = 0; m < 4; m++) begin
				wr(timer_ctl_pkg::OFS_CONFIG, 32'(c));
				wr(timer_ctl_pkg::OFS_B_MODE, 32'(m));
				wr(timer_ctl_pkg::OFS_A_MODE, 32'(3 - m));
				settle;
				check(32'({b_one_shot, b_periodic, b_capture}), 32'(mf(m)));
				check(32'({a_one_shot, a_periodic, a_capture}), 32'(mf(3 - m)));
			end
		end
		// Wide timer: half B mode ignored, half A mode rules
		wr(timer_ctl_pkg::OFS_A_MODE, 32'h0000_0001);
		wr(timer_ctl_pkg::OFS_B_MODE, 32'h0000_0002);
		wr(timer_ctl_pkg::OFS_CONTROL, 32'h0000_0111);
		wr(timer_ctl_pkg::OFS_CONFIG, 32'h0000_0000);
		settle;
		check(32'({b_one_shot, b_periodic, b_capture, b_run}), 32'h0000_0000);
		check(32'({a_one_shot, a_periodic, a_capture, a_run}), 32'h0000_0009);
		check(32'(calendar_run), 32'h0000_0000);
		wr(timer_ctl_pkg::OFS_A_MODE, 32'h0000_0002);
		settle;
		check(32'({a_one_shot, a_periodic, a_capture}), 32'h0000_0002);
		wr(timer_ctl_pkg::OFS_CONFIG, 32'h0000_0001);
		settle;
		check(32'({calendar_run, a_one_shot, a_run}), 32'h0000_0005);
		wr(timer_ctl_pkg::OFS_CONTROL, 32'h0000_0101);
		settle;
		check(32'(calendar_run), 32'h0000_0000);
		// Reserved configs leave both halves idle though enabled
		for (int c = 2; c < 4; c++) begin
			wr(timer_ctl_pkg::OFS_CONFIG, 32'(c));
			settle;
			check(32'({a_run, a_periodic, b_run, b_periodic}), 32'h0000_0000);
		end
		wr(timer_ctl_pkg::OFS_CONFIG, 32'h0000_0004);
		// Edge codes, the two halves crossed
		for (int e = 0; e < 4; e++) begin
			wr(timer_ctl_pkg::OFS_CONTROL, 32'h0000_0101 | 32'(e << 2) | 32'((3 - e) << 10));
			settle;
			check(32'({a_rise_evt, a_fall_evt}), 32'(ef(e)));
			check(32'({b_rise_evt, b_fall_evt}), 32'(ef(3 - e)));
		end
		// Capture kind and PWM set-up of both halves
		for (int k = 0; k < 4; k++) begin
			wr(timer_ctl_pkg::OFS_B_MODE, k[0] ? 32'h0000_0007 : 32'h0000_0003);
			wr(timer_ctl_pkg::OFS_A_MODE, k[0] ? 32'h0000_0007 : 32'h0000_0003);
			settle;
			check(32'({b_capture, b_edge_time}), k[0] ? 32'h0000_0003 : 32'h0000_0002);
			check(32'({a_capture, a_edge_time}), k[0] ? 32'h0000_0003 : 32'h0000_0002);
			wr(timer_ctl_pkg::OFS_B_MODE, k[0] ? 32'h0000_000a : 32'h0000_0002);
			wr(timer_ctl_pkg::OFS_A_MODE, k[0] ? 32'h0000_000a : 32'h0000_0002);
			settle;
			check(32'({b_periodic, b_pwm_mode}), k[0] ? 32'h0000_0003 : 32'h0000_0002);
			check(32'({a_periodic, a_pwm_mode}), k[0] ? 32'h0000_0003 : 32'h0000_0002);
		end
		// Debug freeze, run and hold as {a_run, a_hold, b_run, b_hold}
		wr(timer_ctl_pkg::OFS_A_MODE, 32'h0000_0002);
		wr(timer_ctl_pkg::OFS_CONTROL, 32'h0000_0303);
		settle;
		check(32'({a_run, a_hold, b_run, b_hold}), 32'h0000_000a);
		halt(1'b1);
		check(32'({a_run, a_hold, b_run, b_hold}), 32'h0000_0005);
		rd(timer_ctl_pkg::OFS_STATUS, d);
		check(d, 32'h0000_000a);
		wr(timer_ctl_pkg::OFS_CONTROL, 32'h0000_0101);
		settle;
		check(32'({a_run, a_hold, b_run, b_hold}), 32'h0000_000a);
		wr(timer_ctl_pkg::OFS_CONTROL, 32'h0000_0001);
		settle;
		check(32'({a_run, a_hold, b_run, b_hold}), 32'h0000_0008);
		wr(timer_ctl_pkg::OFS_CONTROL, 32'h0000_0100);
		settle;
		check(32'({a_run, a_hold, b_run, b_hold}), 32'h0000_0002);
		halt(1'b0);
		// Inversion and trigger gate; converter assumed armed on this source
		for (int k = 0; k < 4; k++) begin
			wr(timer_ctl_pkg::OFS_CONTROL, 32'h0000_0001 | 32'((k % 2) << 6) | 32'((k / 2) << 5));
			settle;
			repeat (8) begin
				r_p = a_pwm_raw;
				r_t = a_trigger_raw;
				@(posedge core_clk);
				#1;
				check(32'(pwm_out), 32'(r_p ^ k[0]));
				check(32'(converter_trigger), 32'(r_t & k[1]));
			end
		end
		// Reset in mid-run clears the control word and the run, trigger and calendar outputs again
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rd(timer_ctl_pkg::OFS_CONTROL, d);
		check(d, 32'h0000_0000);
		check(32'({a_run, b_run, converter_trigger, calendar_run}), 32'h0000_0000);
		final_report;
	end
endmodule : testbench
`default_nettype wire
